//--- src/ptd_defines.vh
// constants for the pump turn-on delay block
`ifndef PTD_DEFINES_VH
`define PTD_DEFINES_VH

`define PTD_CLK_HZ        200000000
`define PTD_DELAY_S       60
`define PTD_GATE_MS       10
`define PTD_THRESH_HZ     3250
`define PTD_SYNC_STAGES   2

`endif

//--- src/ptd_pump_delay.v
// pump turn-on detector and hard-wired delay stage
// Operation
// - pump only after threshold rise, then delay
// - decision from primary conductivity channel only
// - fixed threshold well above zero-conductivity frequency
// - about 2500 Hz keeps detector low
// - about 4000 Hz drives detector high
// - detector output feeds delay stage unchanged
// - pump enable 60 seconds after input rises
`timescale 1ns/1ps
`include "ptd_defines.vh"

module ptd_pump_delay #(
  parameter CLK_HZ     = `PTD_CLK_HZ,
  parameter DELAY_S    = `PTD_DELAY_S,
  parameter GATE_MS    = `PTD_GATE_MS,
  parameter THRESH_HZ  = `PTD_THRESH_HZ,
  parameter GATE_CYC   = CLK_HZ / 1000 * GATE_MS,
  // 12e9 cycles at full size, beyond a 32-bit integer parameter
  parameter [63:0] DELAY_CYC = 64'd1 * CLK_HZ * DELAY_S,
  parameter THRESH_CNT = (THRESH_HZ * GATE_MS + 999) / 1000
) (
  input  wire clk_sys,
  input  wire rstn,
  input  wire primary_conductivity_channel,
  output wire thresh_above,
  output wire pump_en
);

  localparam GW = 32;
  localparam DW = 40;
  localparam EW = 16;
  localparam SW = `PTD_SYNC_STAGES;

  // delay stage states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WAIT = 2'h1;
  localparam [1:0] ST_ON   = 2'h2;

  localparam [GW-1:0] GATE_LAST  = GATE_CYC[GW-1:0] - {{(GW-1){1'b0}}, 1'b1};
  localparam [DW-1:0] DELAY_LAST = DELAY_CYC[DW-1:0] - {{(DW-1){1'b0}}, 1'b1};
  localparam [EW-1:0] THRESH_LIM = THRESH_CNT[EW-1:0];

  reg  [SW-1:0] rst_sync_q;
  wire          rst_n_i;
  reg           sq_q;
  reg           sq_prev_q;
  reg  [GW-1:0] gate_q;
  reg  [EW-1:0] edge_q;
  reg           above_q;
  wire          stage_in;
  reg  [1:0]    st_q;
  reg  [1:0]    st_d;
  reg  [DW-1:0] dly_q;
  reg  [DW-1:0] dly_d;
  reg           pump_q;
  reg           pump_d;
  wire          rise;
  wire          gate_end;

  // one step of the gate counter
  function [GW-1:0] gate_inc;
    input [GW-1:0] v;
    begin
      gate_inc = v + {{(GW-1){1'b0}}, 1'b1};
    end
  endfunction

  // one step of the delay counter
  function [DW-1:0] dly_inc;
    input [DW-1:0] v;
    begin
      dly_inc = v + {{(DW-1){1'b0}}, 1'b1};
    end
  endfunction

  // saturating tally, a runaway input must not wrap to a low count
  function [EW-1:0] edge_add;
    input [EW-1:0] v;
    input          inc;
    begin
      if (inc && (v != {EW{1'b1}})) begin
        edge_add = v + {{(EW-1){1'b0}}, 1'b1};
      end else begin
        edge_add = v;
      end
    end
  endfunction

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= {SW{1'b0}};
    end else begin
      rst_sync_q <= {rst_sync_q[SW-2:0], 1'b1};
    end
  end

  assign rst_n_i = rst_sync_q[SW-1];

  // frequency measured by counting rising edges over a fixed gate
  assign rise     = sq_q & ~sq_prev_q;
  assign gate_end = (gate_q == GATE_LAST);

  always @(posedge clk_sys or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sq_q      <= 1'b0;
      sq_prev_q <= 1'b0;
    end else begin
      sq_q      <= primary_conductivity_channel;
      sq_prev_q <= sq_q;
    end
  end

  always @(posedge clk_sys or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_q <= {GW{1'b0}};
    end else if (gate_end) begin
      gate_q <= {GW{1'b0}};
    end else begin
      gate_q <= gate_inc(gate_q);
    end
  end

  always @(posedge clk_sys or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_q <= {EW{1'b0}};
    end else if (gate_end) begin
      edge_q <= {EW{1'b0}};
    end else begin
      edge_q <= edge_add(edge_q, rise);
    end
  end

  // level holds for a whole gate, so it only moves at gate ends
  always @(posedge clk_sys or negedge rst_n_i) begin
    if (!rst_n_i) begin
      above_q <= 1'b0;
    end else if (gate_end) begin
      // fixed threshold, no software trim so air drift cannot start it
      above_q <= (edge_add(edge_q, rise) >= THRESH_LIM);
    end
  end

  assign stage_in = above_q;

  always @(posedge clk_sys or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q   <= ST_IDLE;
      dly_q  <= {DW{1'b0}};
      pump_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      dly_q  <= dly_d;
      pump_q <= pump_d;
    end
  end

  // pump rises DELAY_CYC edges after the level is first seen high
  always @* begin
    st_d   = st_q;
    dly_d  = dly_q;
    pump_d = pump_q;
    case (st_q)
      ST_IDLE,
      ST_WAIT: begin
        if (!stage_in) begin
          st_d   = ST_IDLE;
          dly_d  = {DW{1'b0}};
          pump_d = 1'b0;
        end else if (dly_q == DELAY_LAST) begin
          st_d   = ST_ON;
          pump_d = 1'b1;
        end else begin
          st_d   = ST_WAIT;
          dly_d  = dly_inc(dly_q);
        end
      end
      ST_ON: begin
        if (!stage_in) begin
          st_d   = ST_IDLE;
          dly_d  = {DW{1'b0}};
          pump_d = 1'b0;
        end
      end
      default: begin
        st_d   = ST_IDLE;
        dly_d  = {DW{1'b0}};
        pump_d = 1'b0;
      end
    endcase
  end

  assign thresh_above = above_q;
  assign pump_en      = pump_q;

endmodule

//--- test/ptd_properties.sv
// pump delay checker
`timescale 1ns/1ps
module ptd_chk(input wire clk_sys, input wire rstn,
  input wire thresh_above, input wire pump_en);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  pump_gated_a: assert property (pump_en |-> $past(thresh_above))
    else $error("pump without level");
  drop_clear_a: assert property (!thresh_above |=> !pump_en)
    else $error("pump not cleared");
  delay_hold_a: assert property ($rose(thresh_above) |-> !pump_en[*8])
    else $error("delay too short");
  pump_rise_a: assert property ($rose(pump_en) |-> thresh_above)
    else $error("pump rose without level");
  pump_hold_a: assert property (pump_en && thresh_above |=> pump_en)
    else $error("pump dropped while level high");
  rise_idle_a: assert property ($rose(thresh_above) |-> !pump_en)
    else $error("delay not restarted");
  pump_rise_c: cover property ($rose(pump_en));
  level_rise_c: cover property ($rose(thresh_above));
  pump_drop_c: cover property ($fell(pump_en));
endmodule
bind ptd_pump_delay ptd_chk chk(.clk_sys(clk_sys), .rstn(rstn),
  .thresh_above(thresh_above), .pump_en(pump_en));

//--- test/ptd_src.sv
// squared conductivity frequency source model
`timescale 1ns/1ps
module ptd_src(input wire logic [15:0] hp, output logic sq);
  initial sq = 1'b0;
  always #(hp) sq = ~sq;
endmodule

//--- test/tb.sv
// pump delay testbench
`timescale 1ns/1ps
module tb;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [15:0] hp = 16'h00c8;
  wire         sq, thresh_above, pump_en;
  int          err_count = 0, n_tests = 0, n;
  always #2.5 clk_sys = ~clk_sys;
  ptd_src src(.hp(hp), .sq(sq));
  // counts per gate match the full-size gate, only time is scaled
  ptd_pump_delay #(.GATE_CYC(2000), .DELAY_CYC(500), .THRESH_CNT(33)) dut(
    .clk_sys(clk_sys), .rstn(rstn), .primary_conductivity_channel(sq),
    .thresh_above(thresh_above), .pump_en(pump_en));
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %0t seen %0h want %0h", $time, s, e);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task wait_n(input logic v, input logic s);
    n = 0;
    while (s !== v && n < 6000) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task low_freq;
    repeat (6000) @(negedge clk_sys);
    chk(thresh_above, 16'h0000);
    chk(pump_en, 16'h0000);
  endtask
  task high_freq;
    hp = 16'h007d;
    n = 0;
    while (thresh_above !== 1'b1 && n < 6000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(thresh_above, 16'h0001);
    n = 0;
    while (pump_en !== 1'b1 && n < 600) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n[15:0], 16'h01f4);
    hp = 16'h00c8;
    while (thresh_above !== 1'b0 && n < 9000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(thresh_above, 16'h0000);
    @(negedge clk_sys);
    chk(pump_en, 16'h0000);
  endtask
  initial begin
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    low_freq;
    high_freq;
    results;
  end
  initial begin
    #150000;
    err_count++;
    results;
  end
endmodule
